// [fabric_model.sv]
// Fabric model that drives operand pairs and sign controls into the tile
`timescale 1ns/100ps
module fabric_model (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic [35:0] fixedData,
  output mult_tile_pkg::operands_type operands
);
  import mult_tile_pkg::*;
  // Fresh random pair each cycle while run is high; one signA and one signB serve both narrow sections
  // Operands stay unknown until the first edge, which falls inside the reset time
  always @(posedge ref_clk) begin
    if (run)
      operands <= {2'($urandom), 36'({$urandom, $urandom})};
    else
      operands <= {2'b00, fixedData};
  end
endmodule // fabric_model

// [mult_slice.sv]
// Full-precision multiplier with per-operand signed or unsigned reading
`timescale 1ns/100ps
module mult_slice #(
  parameter int WIDTH = 9
) (
  input wire logic [WIDTH-1:0] opA,
  input wire logic [WIDTH-1:0] opB,
  input wire logic signA,
  input wire logic signB,
  output logic [2*WIDTH-1:0] prod
);

  logic signed [WIDTH:0] extA;
  logic signed [WIDTH:0] extB;
  logic signed [2*WIDTH+1:0] full;

  // One extra bit lets a single signed multiply cover all four sign mixes
  assign extA = {signA & opA[WIDTH-1], opA};
  assign extB = {signB & opB[WIDTH-1], opB};
  assign full = extA * extB;
  // The top two bits are only sign copies, so nothing is lost here
  assign prod = full[2*WIDTH-1:0];

endmodule // mult_slice

// [mult_tile.sv]
// Embedded multiplier tile: one 18x18 or two 9x9 multipliers with optional registers
// What this block does
// - Each operand may be registered or fed straight to the array, independently.
// - Operands are handled in 9-bit or 18-bit sections, set by mode.
// - Every input register has clock, clock enable and asynchronous clear.
// - All tile registers share one clock, one enable and one clear.
// - Sign control A high reads operand A as two's complement, else unsigned.
// - Sign control B selects signed or unsigned operand B the same way.
// - Product is signed if any operand is signed; unsigned only if both unsigned.
// - Product is always full precision, never truncated or rounded.
// - One A and one B sign control per tile, shared by both narrow multipliers.
// - Sign controls may change at run time and have optional own registers.
// - With sign controls unused the tile multiplies unsigned.
// - Product optionally registered in 18- or 36-bit sections, same controls.
// - Tile runs as one wide multiplier or two independent narrow ones.
// - Wide mode multiplies two operands of 10 to 18 bits.
// - Dual mode multiplies two independent pairs of at most 9 bits.
// - In dual mode each operand and product section registers independently.
`timescale 1ns/100ps
`include "mult_tile_consts.svh"
module mult_tile (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic tileClkEn,
  input wire logic tileClear,
  input wire mult_tile_pkg::operands_type operands,
  output logic [35:0] product
);
  import mult_tile_pkg::*;

  // Software state
  tileCfg_type cfg_reg;
  tileCfg_type cfg_next;
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;

  // Tile datapath registers
  logic [17:0] opA_reg;
  logic [17:0] opA_next;
  logic [17:0] opB_reg;
  logic [17:0] opB_next;
  logic signA_reg;
  logic signA_next;
  logic signB_reg;
  logic signB_next;
  logic [35:0] prod_reg;
  logic [35:0] prod_next;

  // Decoded and selected values
  logic isDual;
  logic [1:0] selRegA;
  logic [1:0] selRegB;
  logic [1:0] selRegOut;
  logic [17:0] opA;
  logic [17:0] opB;
  logic rawSignA;
  logic rawSignB;
  logic effSignA;
  logic effSignB;
  logic [35:0] wideProd;
  logic [17:0] narrowProd [`SECTIONS];
  logic [35:0] arrayProd;
  logic [35:0] prodOut;
  logic signedProd;
  logic hitConfig;
  logic hitProdLo;
  logic hitProdHi;
  logic hitStatus;
  logic [31:0] statusWord;

  //--------------------------------------------------------------------
  // Register port
  //--------------------------------------------------------------------

  // Address decode of the plain register port
  assign hitConfig = (regAddr == `ADDR_CONFIG);
  assign hitProdLo = (regAddr == `ADDR_PROD_LO);
  assign hitProdHi = (regAddr == `ADDR_PROD_HI);
  assign hitStatus = (regAddr == `ADDR_STATUS);

  // Configuration takes the low bits of a write; upper bits are ignored
  assign cfg_next = (regWrite && hitConfig) ?
                    tileCfg_type'(regWrData[`CFG_WIDTH-1:0]) : cfg_reg;

  // Status shows the live mode and the sign reading in force
  assign statusWord = {28'h0000000, signedProd, effSignB, effSignA, isDual};

  // Read data for the cycle after the strobe; unmapped reads return zero
  assign rdData_next = !regRead ? 32'h00000000 :
                       hitConfig ? {22'h000000, cfg_reg} :
                       hitProdLo ? prodOut[31:0] :
                       hitProdHi ? {28'h0000000, prodOut[35:32]} :
                       hitStatus ? statusWord :
                       32'h00000000;

  // Software registers are reset by the system reset only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_reg <= tileCfg_type'(`CFG_RESET);
      rdData_reg <= 32'h00000000;
    end else begin
      cfg_reg <= cfg_next;
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;

  //--------------------------------------------------------------------
  // Mode and register selection
  //--------------------------------------------------------------------

  // Only two modes exist; the mode bit picks one of them
  assign isDual = (cfg_reg.mode == MODE_DUAL);

  // Wide mode treats an operand as one 18-bit section steered by bit 0
  assign selRegA = isDual ? cfg_reg.regA : {2{cfg_reg.regA[0]}};
  assign selRegB = isDual ? cfg_reg.regB : {2{cfg_reg.regB[0]}};
  assign selRegOut = isDual ? cfg_reg.regOut : {2{cfg_reg.regOut[0]}};

  //--------------------------------------------------------------------
  // Input registers
  //--------------------------------------------------------------------

  // Sign controls are gated off when software marks them unused
  assign rawSignA = cfg_reg.signUse & operands.signA;
  assign rawSignB = cfg_reg.signUse & operands.signB;

  // A low tile enable makes every tile register reload its own value
  assign opA_next = tileClkEn ? operands.dataA : opA_reg;
  assign opB_next = tileClkEn ? operands.dataB : opB_reg;
  assign signA_next = tileClkEn ? rawSignA : signA_reg;
  assign signB_next = tileClkEn ? rawSignB : signB_reg;

  // Clear acts without the clock so the tile empties in the same cycle
  always_ff @(posedge ref_clk or posedge tileClear) begin
    if (tileClear) begin
      opA_reg <= 18'h00000;
      opB_reg <= 18'h00000;
      signA_reg <= 1'b0;
      signB_reg <= 1'b0;
    end else if (!rst_n) begin
      opA_reg <= 18'h00000;
      opB_reg <= 18'h00000;
      signA_reg <= 1'b0;
      signB_reg <= 1'b0;
    end else begin
      opA_reg <= opA_next;
      opB_reg <= opB_next;
      signA_reg <= signA_next;
      signB_reg <= signB_next;
    end
  end

  // Each 9-bit section of each operand picks its register or the raw pin
  for (genvar s = 0; s < `SECTIONS; s++) begin : g_inSel
    assign opA[9*s+8:9*s] = selRegA[s] ?
                            opA_reg[9*s+8:9*s] : operands.dataA[9*s+8:9*s];
    assign opB[9*s+8:9*s] = selRegB[s] ?
                            opB_reg[9*s+8:9*s] : operands.dataB[9*s+8:9*s];
  end

  // Sign controls follow their own dedicated registers when chosen
  assign effSignA = cfg_reg.regSignA ? signA_reg : rawSignA;
  assign effSignB = cfg_reg.regSignB ? signB_reg : rawSignB;

  // The product is signed as soon as either operand is
  assign signedProd = effSignA | effSignB;

  //--------------------------------------------------------------------
  // Multiplier array
  //--------------------------------------------------------------------

  // Wide multiplier; narrower operands arrive sign or zero extended to 18 bits
  mult_slice #(
    .WIDTH(`OPERAND_WIDTH)
  ) u_wide (
    .opA(opA),
    .opB(opB),
    .signA(effSignA),
    .signB(effSignB),
    .prod(wideProd)
  );

  // Two narrow multipliers, both driven by the one pair of sign controls
  for (genvar s = 0; s < `SECTIONS; s++) begin : g_narrow
    mult_slice #(
      .WIDTH(`SECTION_WIDTH)
    ) u_narrow (
      .opA(opA[9*s+8:9*s]),
      .opB(opB[9*s+8:9*s]),
      .signA(effSignA),
      .signB(effSignB),
      .prod(narrowProd[s])
    );
  end

  // Product layout: one 36-bit word, or product 1 above product 0
  assign arrayProd = isDual ? {narrowProd[1], narrowProd[0]} : wideProd;

  //--------------------------------------------------------------------
  // Output registers
  //--------------------------------------------------------------------

  // Output registers hold under a low enable, like the input side
  assign prod_next = tileClkEn ? arrayProd : prod_reg;

  // Same clock, enable and clear as the input registers
  always_ff @(posedge ref_clk or posedge tileClear) begin
    if (tileClear) begin
      prod_reg <= 36'h000000000;
    end else if (!rst_n) begin
      prod_reg <= 36'h000000000;
    end else begin
      prod_reg <= prod_next;
    end
  end

  // Each 18-bit section of the result picks its register or the array
  for (genvar s = 0; s < `SECTIONS; s++) begin : g_outSel
    assign prodOut[18*s+17:18*s] = selRegOut[s] ?
                                   prod_reg[18*s+17:18*s] :
                                   arrayProd[18*s+17:18*s];
  end

  // An unregistered product is combinational from the pins by design
  assign product = prodOut;

endmodule // mult_tile

// [mult_tile_assertions.sv]
// Concurrent port checks for the multiplier tile
`timescale 1ns/100ps
module mult_tile_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic tileClkEn,
  input wire logic tileClear,
  input wire mult_tile_pkg::operands_type operands,
  input wire logic [35:0] product
);
  import mult_tile_pkg::*;
  logic [9:0] cfgShadow_reg;
  // Reference products; signs count only while sign use is on
  wire logic sa = operands.signA & cfgShadow_reg[1];
  wire logic sb = operands.signB & cfgShadow_reg[1];
  wire logic [37:0] sProd = $signed({sa & operands.dataA[17], operands.dataA})
    * $signed({sb & operands.dataB[17], operands.dataB});
  wire logic [19:0] dLo = $signed({sa & operands.dataA[8], operands.dataA[8:0]})
    * $signed({sb & operands.dataB[8], operands.dataB[8:0]});
  wire logic [19:0] dHi = $signed({sa & operands.dataA[17], operands.dataA[17:9]})
    * $signed({sb & operands.dataB[17], operands.dataB[17:9]});
  // An edge that loads registers and leaves the configuration alone
  wire logic step = rst_n && tileClkEn && !tileClear && !regWrite;
  // Shadow of the configuration, so each check knows the mode in force
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      cfgShadow_reg <= 10'h000;
    else if (regWrite && regAddr == 4'h0)
      cfgShadow_reg <= regWrData[9:0];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_wide_direct_product: assert property (
    cfgShadow_reg[9:2] == 8'h00 && !cfgShadow_reg[0] |-> product == sProd[35:0])
    else $error("wide unregistered product wrong");
  a_dual_direct_product: assert property (
    cfgShadow_reg[9:2] == 8'h00 && cfgShadow_reg[0] |-> product == {dHi[17:0], dLo[17:0]})
    else $error("dual unregistered products wrong");
  a_out_reg_delay: assert property (
    cfgShadow_reg == 10'h100 && $past(step) && !tileClear |-> product == $past(sProd[35:0]))
    else $error("output register delay wrong");
  a_a_only_reg: assert property (
    cfgShadow_reg == 10'h004 && $past(step) && !tileClear
    |-> product == 36'($past(operands.dataA)) * operands.dataB)
    else $error("operand A register path wrong");
  a_full_pipe_delay: assert property (
    cfgShadow_reg == 10'h3FE && $past(step) && $past(step, 2) && !tileClear
    |-> product == $past(sProd[35:0], 2))
    else $error("fully registered product wrong");
  a_dual_mixed_regs: assert property (
    cfgShadow_reg == 10'h005 && $past(step) && !tileClear
    |-> product == {dHi[17:0], 18'($past(operands.dataA[8:0])) * operands.dataB[8:0]})
    else $error("dual section registers not independent");
  a_clear_zeroes_out: assert property (
    tileClear && cfgShadow_reg[8] && !cfgShadow_reg[0] |-> product == 36'h0)
    else $error("clear left product nonzero");
  a_hold_no_enable: assert property (
    cfgShadow_reg[9:2] == 8'hFF && !tileClkEn && !tileClear && !regWrite
    |=> tileClear || $stable(product))
    else $error("product moved with enable low");
endmodule // mult_tile_assertions

bind mult_tile mult_tile_assertions chk (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .tileClkEn(tileClkEn), .tileClear(tileClear), .operands(operands), .product(product));

// [mult_tile_consts.svh]
// Register offsets, field positions and reset values of the multiplier tile
`ifndef MULT_TILE_CONSTS_SVH
`define MULT_TILE_CONSTS_SVH

// Register offsets (byte addresses on the plain register port)
`define ADDR_CONFIG 4'h0
`define ADDR_PROD_LO 4'h4
`define ADDR_PROD_HI 4'h8
`define ADDR_STATUS 4'hC

// Configuration register field positions
`define CFG_MODE_BIT 0
`define CFG_SIGN_USE_BIT 1
`define CFG_REG_A_LSB 2
`define CFG_REG_B_LSB 4
`define CFG_REG_SIGN_A_BIT 6
`define CFG_REG_SIGN_B_BIT 7
`define CFG_REG_OUT_LSB 8
`define CFG_WIDTH 10

// Configuration reset value: wide mode, signs unused, nothing registered
`define CFG_RESET 10'h000

// Status register field positions
`define STAT_MODE_BIT 0
`define STAT_SIGN_A_BIT 1
`define STAT_SIGN_B_BIT 2
`define STAT_SIGNED_PROD_BIT 3

// Datapath widths
`define SECTION_WIDTH 9
`define OPERAND_WIDTH 18
`define PRODUCT_WIDTH 36
`define SECTIONS 2

`endif

// [mult_tile_pkg.sv]
// Types shared by the multiplier tile, its fabric model, its checker and its bench
package mult_tile_pkg;

  // Tile operating mode
  typedef enum logic {
    MODE_WIDE,
    MODE_DUAL
  } mode_type;

  // Software configuration of the tile
  typedef struct packed {
    logic [1:0] regOut;
    logic regSignB;
    logic regSignA;
    logic [1:0] regB;
    logic [1:0] regA;
    logic signUse;
    mode_type mode;
  } tileCfg_type;

  // One operand pair with its sign controls
  typedef struct packed {
    logic signA;
    logic signB;
    logic [17:0] dataA;
    logic [17:0] dataB;
  } operands_type;

endpackage

// [test_embedded_multiplier_block.sv]
// Self-checking bench for the multiplier tile with a fabric operand model
`timescale 1ns/100ps
module test_embedded_multiplier_block;
  import mult_tile_pkg::*;
  localparam logic [9:0] CFGS [7] = '{10'h000, 10'h002, 10'h003, 10'h001, 10'h100,
    10'h004, 10'h005};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic tileClkEn = 1'b1;
  logic tileClear = 1'b0;
  logic run = 1'b0;
  logic rdPending = 1'b0;
  logic [35:0] fixedData = 36'h0;
  logic [35:0] heldProd = 36'h3FFFF * 36'h20003;
  logic [31:0] regRdData;
  logic [35:0] product;
  operands_type operands;
  logic [31:0] expectQ[$];
  int nErrors = 0;
  int samplesChecked = 0;
  mult_tile DUT (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .tileClkEn(tileClkEn),
    .tileClear(tileClear), .operands(operands), .product(product));
  fabric_model fabric (.ref_clk(ref_clk), .run(run), .fixedData(fixedData),
    .operands(operands));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    samplesChecked++;
    if (seen !== want) begin
      nErrors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  // Note the expected answer now; the watcher below compares it when it stands
  task automatic rd(input logic [3:0] a, input logic [31:0] want);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    expectQ.push_back(want);
    @(posedge ref_clk);
    regRead <= 1'b0;
  endtask
  task automatic report_and_stop();
    if (nErrors == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rdPending)
      check(regRdData, expectQ.pop_front());
    rdPending <= regRead;
  end
  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (20000) @(posedge ref_clk);
    nErrors++;
    $display("unexpected at %0t: run did not finish", $time);
    report_and_stop();
  end
  initial begin
    void'($urandom(63));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'hC, 32'h0);
    rd(4'h2, 32'h0);
    run <= 1'b1;
    // Both modes, sign use, and the A and output register options, with random enable and clear under the checker
    foreach (CFGS[i]) begin
      wr(4'h0, 32'(CFGS[i]));
      repeat (60) begin
        @(posedge ref_clk);
        tileClkEn <= 1'($urandom);
        tileClear <= ($urandom % 16 == 0);
      end
      rd(4'h0, 32'(CFGS[i]));
    end
    // Load a fixed pair fully registered, then freeze it and read back its low 32 and high 4 bits
    tileClkEn <= 1'b1;
    tileClear <= 1'b0;
    run <= 1'b0;
    fixedData <= {18'h3FFFF, 18'h20003};
    wr(4'h0, 32'h3FC);
    repeat (3) @(posedge ref_clk);
    tileClkEn <= 1'b0;
    run <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(4'h4, heldProd[31:0]);
    rd(4'h8, {28'h0, heldProd[35:32]});
    tileClear <= 1'b1;
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0);
    tileClear <= 1'b0;
    tileClkEn <= 1'b1;
    wr(4'h4, 32'hFFFF_FFFF);
    rd(4'h0, 32'h3FC);
    wr(4'h0, 32'h3FE);
    repeat (200) @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(4'h0, 32'h0);
    repeat (3) @(posedge ref_clk);
    report_and_stop();
  end
endmodule // test_embedded_multiplier_block
